/* core/ocu_pkg.sv */
// Package of register map, field positions and mode codes for the output compare unit
package ocu_pkg;
   // =====================================================================
   // Register word addresses on the Avalon-MM bus
   // =====================================================================
   localparam logic [3:0] ADDR_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_PRIMARY   = 4'h1;
   localparam logic [3:0] ADDR_SECONDARY = 4'h2;
   localparam logic [3:0] ADDR_STATUS    = 4'h3;
   localparam logic [3:0] ADDR_MASK      = 4'h4;
   localparam logic [3:0] ADDR_PERIOD2   = 4'h5;
   localparam logic [3:0] ADDR_PERIOD3   = 4'h6;

   // =====================================================================
   // Control register fields
   // =====================================================================
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_TSEL_BIT = 3;
   localparam int CTL_FLT_BIT  = 4;
   localparam int CTL_SIDL_BIT = 13;
   localparam logic [15:0] CTL_WMASK = 16'h200F;
   localparam logic [15:0] CTL_RESET = 16'h0000;

   // Interrupt status bits
   localparam int IRQ_OUT_BIT   = 0;
   localparam int IRQ_FAULT_BIT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   // =====================================================================
   // Mode codes
   // =====================================================================
   typedef enum logic [2:0] {
      MODE_OFF    = 3'h0,
      MODE_ONE_LO = 3'h1,
      MODE_ONE_HI = 3'h2,
      MODE_TOGGLE = 3'h3,
      MODE_DELAY  = 3'h4,
      MODE_CONT   = 3'h5,
      MODE_PWM    = 3'h6,
      MODE_PWM_FP = 3'h7
   } ocu_mode_e;
endpackage

/* core/ocu_output_compare_unit.sv */
// Output compare channel with Avalon-MM register slave and interrupt logic
//
// Contract
// RULE1: Mode zero disables channel; pin follows general-purpose port value.
// RULE2: Active-low one-shot: start low, match drives high, interrupt on rise.
// RULE3: Active-high one-shot: start high, match drives low, interrupt on fall.
// RULE4: Toggle: keep level on entry, invert each match, interrupt both edges.
// RULE5: Delayed one-shot: start low, one pulse from matches, interrupt on fall.
// RULE6: Continuous pulse: start low, repeated pulses, interrupt each fall.
// RULE7: PWM no fault: ignore fault, start low if primary zero, no interrupt.
// RULE8: PWM with fault: honour fault, same start, interrupt on fault fall.
// RULE9: Fault flag bit 4 set on fault in mode 111, cleared by hardware.
// RULE10: Bit 3 selects time base: one third timer, zero second timer.
// RULE11: Bit 13 set halts the channel in idle; clear keeps it running.
// RULE12: Software stops the selected timer before writing the control register.
// RULE13: Unused control bits always read as zero.
// RULE14: Compare selected count with one or two values; match changes pin.
// RULE15: PWM: active at period start, inactive at primary; fault forces low.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module ocu_output_compare_unit (
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [1:0]  avs_response,
   // Time bases (same clock domain)
   input  wire logic [15:0] timer2_count,
   input  wire logic [15:0] timer3_count,
   input  wire logic        cpu_idle,
   input  wire logic        gpio_value,
   // Pins
   input  wire logic        fault_input,
   output logic             compare_output_pin,
   output logic             irq
);
   // ======================================================================
   // State
   // ======================================================================
   typedef struct packed {
      logic        sidl;
      logic        tsel;
      logic        flt;
      logic [2:0]  mode;
      logic [15:0] pri;
      logic [15:0] sec;
      logic [15:0] per2;
      logic [15:0] per3;
      logic [1:0]  stat;
      logic [1:0]  mask;
      logic        pin;
      logic        done;
      logic        fsync1;
      logic        fsync2;
      logic        fprev;
      logic [31:0] rdata;
      logic        ack;
   } ocu_state_s;

   ocu_state_s st_q;
   ocu_state_s st_d;

   // Word index of an Avalon byte address pair is the address itself
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      logic [15:0] r;
      r = old_v;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   logic [15:0] count;
   logic [15:0] period;
   logic        halted;
   logic        m_pri;
   logic        m_sec;
   logic        m_per;
   logic        pwm_mode;
   logic        fault_active;
   logic        fault_fall;
   logic        rise;
   logic        fall;
   logic [15:0] ctl_rd;
   logic        wr_ctl;
   logic        acc;
   logic        wr_go;

   // Local short names for the mode codes
   localparam logic [2:0] MODE_ONE_LO_T = ocu_pkg::MODE_ONE_LO;
   localparam logic [2:0] MODE_ONE_HI_T = ocu_pkg::MODE_ONE_HI;
   localparam logic [2:0] MODE_TOGGLE_T = ocu_pkg::MODE_TOGGLE;
   localparam logic [2:0] MODE_DELAY_T  = ocu_pkg::MODE_DELAY;
   localparam logic [2:0] MODE_CONT_T   = ocu_pkg::MODE_CONT;
   localparam logic [2:0] MODE_PWM_T    = ocu_pkg::MODE_PWM;
   localparam logic [2:0] MODE_PWM_FP_T = ocu_pkg::MODE_PWM_FP;

   // ======================================================================
   // Next state
   // ======================================================================
   always_comb begin
      st_d = st_q;
      // Fault pin passes two flops before any logic reads it
      st_d.fsync1 = fault_input;
      st_d.fsync2 = st_q.fsync1;
      st_d.fprev  = st_q.fsync2;

      count  = st_q.tsel ? timer3_count : timer2_count;      // [RULE10]
      period = st_q.tsel ? st_q.per3 : st_q.per2;
      halted = st_q.sidl && cpu_idle;                        // [RULE11]
      m_pri  = !halted && (count == st_q.pri);                // [RULE14]
      m_sec  = !halted && (count == st_q.sec);                // [RULE14]
      m_per  = !halted && (count == period);
      pwm_mode     = (st_q.mode == MODE_PWM_T) || (st_q.mode == MODE_PWM_FP_T);
      fault_active = (st_q.mode == MODE_PWM_FP_T) && !st_q.fsync2;  // Fault pin active low
      fault_fall   = (st_q.mode == MODE_PWM_FP_T) && st_q.fprev && !st_q.fsync2;

      // Bus access: one-cycle wait, then answer
      acc    = (avs_read || avs_write) && !st_q.ack;
      // Writes commit at the answer edge, where the master sees the wait drop
      wr_go  = avs_write && st_q.ack;
      wr_ctl = wr_go && (avs_address == ocu_pkg::ADDR_CONTROL);
      st_d.ack = acc;

      // Compare engine
      unique case (st_q.mode)
         MODE_ONE_LO_T: begin
            if (m_pri) begin
               st_d.pin = 1'b1;                              // [RULE2]
            end
         end
         MODE_ONE_HI_T: begin
            if (m_pri) begin
               st_d.pin = 1'b0;                              // [RULE3]
            end
         end
         MODE_TOGGLE_T: begin
            if (m_pri) begin
               st_d.pin = !st_q.pin;                         // [RULE4]
            end
         end
         MODE_DELAY_T: begin
            if (m_pri && !st_q.done) begin
               st_d.pin = 1'b1;                              // [RULE5]
            end else if (m_sec && st_q.pin) begin
               st_d.pin  = 1'b0;                             // [RULE5]
               st_d.done = 1'b1;
            end
         end
         MODE_CONT_T: begin
            if (m_pri) begin
               st_d.pin = 1'b1;                              // [RULE6]
            end else if (m_sec) begin
               st_d.pin = 1'b0;                              // [RULE6]
            end
         end
         MODE_PWM_T, MODE_PWM_FP_T: begin
            // Primary match wins when duty equals period: stays inactive
            if (m_pri) begin
               st_d.pin = 1'b0;                              // [RULE15]
            end else if (m_per) begin
               st_d.pin = 1'b1;                              // [RULE15]
            end
            if (fault_active) begin
               st_d.pin = 1'b0;                              // [RULE15] [RULE8]
               st_d.flt = 1'b1;                              // [RULE9]
            end else if (m_per) begin
               st_d.flt = 1'b0;                              // [RULE9]
            end
         end
         default: begin
            st_d.pin = 1'b0;                                 // [RULE1]
         end
      endcase

      // Output edges feed the sticky status
      rise = !st_q.pin && st_d.pin;
      fall = st_q.pin && !st_d.pin;
      if (st_q.mode == MODE_ONE_LO_T && rise) begin
         st_d.stat[ocu_pkg::IRQ_OUT_BIT] = 1'b1;             // [RULE2]
      end
      if ((st_q.mode == MODE_ONE_HI_T || st_q.mode == MODE_DELAY_T
           || st_q.mode == MODE_CONT_T) && fall) begin
         st_d.stat[ocu_pkg::IRQ_OUT_BIT] = 1'b1;             // [RULE3] [RULE5] [RULE6]
      end
      if (st_q.mode == MODE_TOGGLE_T && (rise || fall)) begin
         st_d.stat[ocu_pkg::IRQ_OUT_BIT] = 1'b1;             // [RULE4]
      end
      if (fault_fall) begin
         st_d.stat[ocu_pkg::IRQ_FAULT_BIT] = 1'b1;           // [RULE8] [RULE7]
      end

      // Register writes; status clear yields to a same-cycle set only where the bit was clear before
      if (wr_go) begin
         unique case (avs_address)
            ocu_pkg::ADDR_PRIMARY: begin
               st_d.pri = merge16(st_q.pri, avs_writedata, avs_byteenable);
            end
            ocu_pkg::ADDR_SECONDARY: begin
               st_d.sec = merge16(st_q.sec, avs_writedata, avs_byteenable);
            end
            ocu_pkg::ADDR_PERIOD2: begin
               st_d.per2 = merge16(st_q.per2, avs_writedata, avs_byteenable);
            end
            ocu_pkg::ADDR_PERIOD3: begin
               st_d.per3 = merge16(st_q.per3, avs_writedata, avs_byteenable);
            end
            ocu_pkg::ADDR_STATUS: begin
               if (avs_byteenable[0]) begin
                  st_d.stat = st_d.stat & ~(st_q.stat & avs_writedata[1:0]
                              & ~(st_d.stat & ~st_q.stat));
               end
            end
            ocu_pkg::ADDR_MASK: begin
               if (avs_byteenable[0]) begin
                  st_d.mask = avs_writedata[1:0];
               end
            end
            default: begin
            end
         endcase
      end

      // Control write: mode entry sets the initial pin level
      if (wr_ctl) begin
         if (avs_byteenable[1]) begin
            st_d.sidl = avs_writedata[ocu_pkg::CTL_SIDL_BIT];
         end
         if (avs_byteenable[0]) begin
            st_d.tsel = avs_writedata[ocu_pkg::CTL_TSEL_BIT];
            st_d.mode = avs_writedata[2:0];
            st_d.done = 1'b0;
            unique case (avs_writedata[2:0])
               MODE_ONE_LO_T, MODE_DELAY_T, MODE_CONT_T: begin
                  st_d.pin = 1'b0;                           // [RULE2] [RULE5] [RULE6]
               end
               MODE_ONE_HI_T: begin
                  st_d.pin = 1'b1;                           // [RULE3]
               end
               MODE_TOGGLE_T: begin
                  st_d.pin = st_q.pin;                       // [RULE4]
               end
               MODE_PWM_T, MODE_PWM_FP_T: begin
                  st_d.pin = (st_d.pri != 16'h0000);         // [RULE7] [RULE8]
                  st_d.flt = 1'b0;
               end
               default: begin
                  st_d.pin = 1'b0;                           // [RULE1]
               end
            endcase
         end
      end

      // Read data, registered at the edge that ends the wait cycle
      ctl_rd = 16'h0000;                                     // [RULE13]
      ctl_rd[ocu_pkg::CTL_SIDL_BIT] = st_q.sidl;
      ctl_rd[ocu_pkg::CTL_FLT_BIT]  = st_q.flt;
      ctl_rd[ocu_pkg::CTL_TSEL_BIT] = st_q.tsel;
      ctl_rd[2:0] = st_q.mode;
      if (acc) begin
         unique case (avs_address)
            ocu_pkg::ADDR_CONTROL:   st_d.rdata = {16'h0000, ctl_rd};
            ocu_pkg::ADDR_PRIMARY:   st_d.rdata = {16'h0000, st_q.pri};
            ocu_pkg::ADDR_SECONDARY: st_d.rdata = {16'h0000, st_q.sec};
            ocu_pkg::ADDR_STATUS:    st_d.rdata = {30'h00000000, st_q.stat};
            ocu_pkg::ADDR_MASK:      st_d.rdata = {30'h00000000, st_q.mask};
            ocu_pkg::ADDR_PERIOD2:   st_d.rdata = {16'h0000, st_q.per2};
            ocu_pkg::ADDR_PERIOD3:   st_d.rdata = {16'h0000, st_q.per3};
            default:                 st_d.rdata = 32'h00000000;
         endcase
      end
   end

   // ======================================================================
   // Registers
   // ======================================================================
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ======================================================================
   // Outputs
   // ======================================================================
   // Mode zero hands the pin back to the port logic
   assign compare_output_pin = (st_q.mode == 3'h0) ? gpio_value : st_q.pin;  // [RULE1]
   assign irq             = |(st_q.stat & st_q.mask);
   assign avs_readdata    = st_q.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
   assign avs_response    = 2'h0;
endmodule
`default_nettype wire

/* dv/ocu_monitor.sv */
// Checker of bus timing, pin levels and interrupt timing at the unit's ports
`timescale 1ns/10ps
`default_nettype none
module ocu_monitor (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  avs_response,
   input wire logic [15:0] timer2_count,
   input wire logic [15:0] timer3_count,
   input wire logic        cpu_idle,
   input wire logic        gpio_value,
   input wire logic        fault_input,
   input wire logic        compare_output_pin,
   input wire logic        irq
);
   // =================================================
   // Shadow of mode and output mask from finished writes
   // =================================================
   logic [2:0] mode_q;
   logic       mask_q;
   logic [2:0] age_q;
   logic       wr_done;
   assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
   // Age saturates, so settled checks need no long counter
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= 3'h0;
         mask_q <= 1'b0;
         age_q  <= 3'h7;
      end else begin
         age_q <= (age_q == 3'h7) ? 3'h7 : age_q + 3'h1;
         if (wr_done && avs_address == ocu_pkg::ADDR_CONTROL) begin
            mode_q <= avs_writedata[2:0];
            age_q  <= 3'h0;
         end
         if (wr_done && avs_address == ocu_pkg::ADDR_MASK) begin
            mask_q <= avs_writedata[0];
         end
      end
   end
   // =================================================
   // Assertions
   // =================================================
   default clocking dc @(posedge clock); endclocking
   default disable iff (!reset_n);
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait too long");
   resp_okay_a: assert property (avs_response == 2'h0)
      else $error("bad response");
   unused_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
      |-> avs_readdata[15:14] == 2'h0 && avs_readdata[12:5] == 8'h00) else $error("unused set");
   gpio_follow_a: assert property (mode_q == 3'h0 |-> compare_output_pin == gpio_value)
      else $error("pin not gpio");
   rise_only_a: assert property (mode_q == 3'h1 && age_q > 3'h2 |-> !$fell(compare_output_pin))
      else $error("low one-shot fell");
   fall_only_a: assert property (mode_q == 3'h2 && age_q > 3'h2 |-> !$rose(compare_output_pin))
      else $error("high one-shot rose");
   fault_low_a: assert property ((mode_q == 3'h7 && !fault_input) [*5] |-> !compare_output_pin)
      else $error("pin high in fault");
   rise_irq_a: assert property (mode_q == 3'h1 && mask_q && age_q == 3'h7
      && $rose(compare_output_pin) |-> ##[0:3] irq) else $error("no irq on rise");
   // Main scenarios reached
   cover property (mode_q == 3'h7 && !fault_input);
   cover property ($rose(irq));
   cover property (mode_q == 3'h5 && $fell(compare_output_pin));
endmodule
bind ocu_output_compare_unit ocu_monitor u_ocu_monitor (.clock(clock), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .timer2_count(timer2_count),
   .timer3_count(timer3_count), .cpu_idle(cpu_idle), .gpio_value(gpio_value),
   .fault_input(fault_input), .compare_output_pin(compare_output_pin), .irq(irq));
`default_nettype wire

/* dv/ocu_pin_load.sv */
// Model of the load on the compare pin: edge counter and pulled-up fault line
`timescale 1ns/10ps
`default_nettype none
module ocu_pin_load (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       pin_level,
   input  wire logic       fault_req,
   output logic            fault_line,
   output logic      [7:0] rise_count,
   output logic      [7:0] fall_count
);
   logic last_q;
   // Pull-up holds the line high unless a fault is shown
   assign fault_line = !fault_req;
   // Edges seen at the clock, as a capturing load would see them
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         last_q     <= 1'b0;
         rise_count <= 8'h00;
         fall_count <= 8'h00;
      end else begin
         last_q     <= pin_level;
         rise_count <= rise_count + 8'(pin_level && !last_q);
         fall_count <= fall_count + 8'(!pin_level && last_q);
      end
   end
endmodule
`default_nettype wire

/* dv/tb_output_compare_unit.sv */
// Bench driving the unit over its bus, its timers and its pin load
`timescale 1ns/10ps
`default_nettype none
module tb_output_compare_unit;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [15:0] timer2_count = 16'h0;
   logic [15:0] timer3_count = 16'h0;
   logic        cpu_idle = 1'b0;
   logic        gpio_value = 1'b0;
   logic        fault_req = 1'b0;
   logic        fault_input;
   logic        pin;
   logic        irq;
   logic [7:0]  rise_count;
   logic [7:0]  fall_count;
   logic [7:0]  r0;
   logic [7:0]  f0;
   logic [31:0] rd;
   logic [6:0]  e;
   int          errors = 0;
   int          total_checks = 0;
   // Per mode: start level, rises, falls, status after first and second pass
   localparam logic [6:0] EXP_TAB [1:5] = '{7'h12, 7'h46, 7'h17, 7'h16, 7'h2B};
   always #5 clock = ~clock;
   ocu_output_compare_unit u_ocu_output_compare_unit (.clock(clock), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(), .timer2_count(timer2_count),
      .timer3_count(timer3_count), .cpu_idle(cpu_idle), .gpio_value(gpio_value),
      .fault_input(fault_input), .compare_output_pin(pin), .irq(irq));
   ocu_pin_load u_ocu_pin_load (.clock(clock), .reset_n(reset_n), .pin_level(pin),
      .fault_req(fault_req), .fault_line(fault_input), .rise_count(rise_count),
      .fall_count(fall_count));
   // =================================================
   // Tasks
   // =================================================
   task automatic complete_run;
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One bus cycle; wait sampled at each rising edge, released right after it
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      if (avs_waitrequest !== 1'b0) begin
         errors++;
         complete_run();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(name, exp, rd);
   endtask
   // Selected timer parked at zero, the other at the primary value as a decoy
   task automatic arm(input logic [15:0] ctl);
      @(posedge clock);
      timer2_count <= ctl[3] ? 16'h0005 : 16'h0000;
      timer3_count <= ctl[3] ? 16'h0000 : 16'h0005;
      bus(1'b1, ocu_pkg::ADDR_CONTROL, {16'h0, ctl});
      repeat (3) @(posedge clock);
      bus(1'b1, ocu_pkg::ADDR_STATUS, 32'h3);
      r0 = rise_count;
      f0 = fall_count;
   endtask
   // One pass of the selected count over 0..19, ending parked at zero
   task automatic sweep(input logic sel);
      for (int c = 0; c <= 20; c++) begin
         @(posedge clock);
         if (sel)
            timer3_count <= 16'(c % 20);
         else
            timer2_count <= 16'(c % 20);
      end
      repeat (4) @(posedge clock);
   endtask
   // =================================================
   // Sequence
   // =================================================
   initial begin
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      rd_chk("control reset", ocu_pkg::ADDR_CONTROL, 32'h0);
      rd_chk("unmapped", 4'hF, 32'h0);
      bus(1'b1, ocu_pkg::ADDR_CONTROL, 32'hFFF8);
      rd_chk("control bits", ocu_pkg::ADDR_CONTROL, 32'h2008);
      gpio_value <= 1'b1;
      repeat (2) @(posedge clock);
      check("gpio high", 32'h1, 32'(pin));
      gpio_value <= 1'b0;
      repeat (2) @(posedge clock);
      check("gpio low", 32'h0, 32'(pin));
      bus(1'b1, ocu_pkg::ADDR_PRIMARY, 32'h5);
      bus(1'b1, ocu_pkg::ADDR_SECONDARY, 32'hA);
      bus(1'b1, ocu_pkg::ADDR_MASK, 32'h3);
      // Odd modes run on the third timer, even ones on the second
      for (int m = 1; m <= 5; m++) begin
         e = EXP_TAB[m];
         arm({12'h0, 1'(m), 3'(m)});
         check("start level", 32'(e[6]), 32'(pin));
         sweep(1'(m));
         rd_chk("status pass 1", ocu_pkg::ADDR_STATUS, 32'(e[1]));
         check("irq pass 1", 32'(e[1]), 32'(irq));
         bus(1'b1, ocu_pkg::ADDR_STATUS, 32'h3);
         sweep(1'(m));
         rd_chk("status pass 2", ocu_pkg::ADDR_STATUS, 32'(e[0]));
         check("rises", 32'(e[5:4]), 32'(rise_count - r0));
         check("falls", 32'(e[3:2]), 32'(fall_count - f0));
      end
      cpu_idle <= 1'b1;
      arm(16'h2005);
      sweep(1'b0);
      check("idle halt", 32'h0, 32'(rise_count - r0));
      arm(16'h0005);
      sweep(1'b0);
      check("idle run", 32'h1, 32'(rise_count - r0));
      cpu_idle <= 1'b0;
      bus(1'b1, ocu_pkg::ADDR_PERIOD2, 32'h13);
      arm(16'h0006);
      check("pwm start", 32'h1, 32'(pin));
      fault_req <= 1'b1;
      sweep(1'b0);
      check("pwm edges", 32'h0101, {16'h0, rise_count - r0, fall_count - f0});
      rd_chk("pwm status", ocu_pkg::ADDR_STATUS, 32'h0);
      fault_req <= 1'b0;
      bus(1'b1, ocu_pkg::ADDR_PRIMARY, 32'h0);
      arm(16'h0006);
      check("pwm zero start", 32'h0, 32'(pin));
      bus(1'b1, ocu_pkg::ADDR_PRIMARY, 32'h5);
      arm(16'h0007);
      check("fault start", 32'h1, 32'(pin));
      fault_req <= 1'b1;
      repeat (6) @(posedge clock);
      check("fault pin", 32'h0, 32'(pin));
      check("fault irq", 32'h1, 32'(irq));
      rd_chk("fault flag", ocu_pkg::ADDR_CONTROL, 32'h17);
      rd_chk("fault event", ocu_pkg::ADDR_STATUS, 32'h2);
      bus(1'b1, ocu_pkg::ADDR_MASK, 32'h1);
      repeat (2) @(posedge clock);
      check("masked irq", 32'h0, 32'(irq));
      fault_req <= 1'b0;
      bus(1'b1, ocu_pkg::ADDR_STATUS, 32'h3);
      rd_chk("status cleared", ocu_pkg::ADDR_STATUS, 32'h0);
      sweep(1'b0);
      rd_chk("flag cleared", ocu_pkg::ADDR_CONTROL, 32'h7);
      check("pwm resumed", 32'h1, 32'(pin));
      complete_run();
   end
endmodule
`default_nettype wire
